// >>> rtl/acs_i2c_slave.sv
// two-wire register slave top: link engine on the link clock, store on clk
module acs_i2c_slave (
    input wire logic clk,
    input wire logic rst,
    input wire logic linkClk,
    input wire logic sclIn,
    output logic sclOut,
    output logic sclOe,
    input wire logic sdaIn,
    output logic sdaOut,
    output logic sdaOe,
    input wire logic csSel,
    input wire logic addressStrapBit
);
    acs_reg_if regBus ();

    // registers and the power-up trim load sit in the system domain
    acs_reg_core u_core (
        .clk(clk),
        .rst(rst),
        .regBus(regBus)
    );

    logic [2:0] rstSync_reg;
    logic linkRst_reg;
    logic [5:0] syncIn;
    logic [5:0] s1_reg;
    logic [5:0] s2_reg;
    logic [5:0] s3_reg;
    logic [5:0] filt_reg;
    logic sclPrev_reg;
    logic sdaPrev_reg;
    logic ackPrev_reg;
    logic sclF;
    logic sdaF;
    logic strapF;
    logic modeI2c;
    logic ackF;
    logic bootF;
    logic sclRise;
    logic sclFall;
    logic startDet;
    logic stopDet;
    logic busEv;
    logic addrMatch;
    logic rxState;
    logic pending;
    logic loadEv;
    logic wrIssue;
    logic rdIssue;
    acs_pkg::acs_state_e state_reg;
    logic [3:0] bitCnt_reg;
    logic [7:0] shift_reg;
    logic [6:0] ptr_reg;
    logic autoInc_reg;
    logic ackDrive_reg;
    logic mAck_reg;
    logic reqTgl_reg;
    logic reqWr_reg;
    logic [6:0] reqAddr_reg;
    logic [7:0] reqWdata_reg;
    logic txValid_reg;
    logic [7:0] txReg_reg;
    logic [2:0] setupCnt_reg;
    logic sdaOe_reg;
    logic sclOe_reg;

    // system reset brought into the link domain; held until two stages agree
    always_ff @(posedge linkClk) begin
        rstSync_reg <= {rstSync_reg[1:0], rst};
        if (rstSync_reg[2] == rstSync_reg[1]) begin
            linkRst_reg <= rstSync_reg[2];
        end
    end

    // pins and store status pass three stages; a change counts once the last two agree
    // at 15 MHz sampling a fast-mode phase spans many samples, so 400 kHz is met
    assign syncIn = {regBus.bootDone, regBus.ackTgl, csSel, addressStrapBit, sclIn, sdaIn};
    always_ff @(posedge linkClk) begin
        if (linkRst_reg) begin
            s1_reg <= acs_pkg::SYNC_IDLE;
            s2_reg <= acs_pkg::SYNC_IDLE;
            s3_reg <= acs_pkg::SYNC_IDLE;
            filt_reg <= acs_pkg::SYNC_IDLE;
        end else begin
            s1_reg <= syncIn;
            s2_reg <= s1_reg;
            s3_reg <= s2_reg;
            filt_reg <= (s3_reg & ~(s2_reg ^ s3_reg)) | (filt_reg & (s2_reg ^ s3_reg));
        end
    end

    assign sclF = filt_reg[acs_pkg::SYN_SCL];
    assign sdaF = filt_reg[acs_pkg::SYN_SDA];
    assign strapF = filt_reg[acs_pkg::SYN_STRAP];
    assign modeI2c = filt_reg[acs_pkg::SYN_MODE]; // low hands the pins to the other port
    assign ackF = filt_reg[acs_pkg::SYN_ACK];
    assign bootF = filt_reg[acs_pkg::SYN_BOOT];

    // previous line levels for edge and condition detection
    always_ff @(posedge linkClk) begin
        if (linkRst_reg) begin
            sclPrev_reg <= 1'b1;
            sdaPrev_reg <= 1'b1;
            ackPrev_reg <= 1'b0;
        end else begin
            sclPrev_reg <= sclF;
            sdaPrev_reg <= sdaF;
            ackPrev_reg <= ackF;
        end
    end

    // bus events; our own drive only moves SDA while SCL is low, so no false conditions
    assign sclRise = sclF && !sclPrev_reg;
    assign sclFall = !sclF && sclPrev_reg;
    assign startDet = sclF && sclPrev_reg && sdaPrev_reg && !sdaF;
    assign stopDet = sclF && sclPrev_reg && !sdaPrev_reg && sdaF;
    assign busEv = !modeI2c || startDet || stopDet;
    assign addrMatch = shift_reg[7:1] == {acs_pkg::SLAVE_ADDR_HI, strapF};
    assign rxState = state_reg inside {acs_pkg::ST_ADDR, acs_pkg::ST_SUB, acs_pkg::ST_WR};
    assign pending = reqTgl_reg != ackPrev_reg;
    assign loadEv = ackF != ackPrev_reg;

    // protocol sequencer: bit count 0..7 data, 8 acknowledge slot
    always_ff @(posedge linkClk) begin
        if (linkRst_reg) begin
            state_reg <= acs_pkg::ST_IDLE;
            bitCnt_reg <= acs_pkg::BIT_FIRST;
            ackDrive_reg <= 1'b0;
        end else if (!modeI2c || stopDet) begin
            state_reg <= acs_pkg::ST_IDLE;
            bitCnt_reg <= acs_pkg::BIT_FIRST;
            ackDrive_reg <= 1'b0;
        end else if (startDet) begin
            state_reg <= acs_pkg::ST_ADDR; // also a repeated start
            bitCnt_reg <= acs_pkg::BIT_LEAD; // the fall after the start is not a bit
            ackDrive_reg <= 1'b0;
        end else if (sclFall) begin
            if (bitCnt_reg < acs_pkg::BIT_LAST || bitCnt_reg == acs_pkg::BIT_LEAD) begin
                bitCnt_reg <= bitCnt_reg + 4'h1;
            end else if (bitCnt_reg == acs_pkg::BIT_LAST) begin
                bitCnt_reg <= acs_pkg::BIT_ACK;
                // not booted yet means the address is left unanswered
                ackDrive_reg <= rxState && (state_reg != acs_pkg::ST_ADDR || (addrMatch && bootF));
            end else begin
                bitCnt_reg <= acs_pkg::BIT_FIRST;
                ackDrive_reg <= 1'b0;
                unique case (state_reg)
                    acs_pkg::ST_ADDR: begin
                        if (!ackDrive_reg) begin
                            state_reg <= acs_pkg::ST_WAIT;
                        end else if (shift_reg[0]) begin
                            state_reg <= acs_pkg::ST_RD;
                        end else begin
                            state_reg <= acs_pkg::ST_SUB;
                        end
                    end
                    acs_pkg::ST_SUB: begin
                        state_reg <= acs_pkg::ST_WR; // direction stays write
                    end
                    acs_pkg::ST_RD: begin
                        if (!mAck_reg) begin
                            state_reg <= acs_pkg::ST_WAIT; // last byte seen, wait for stop
                        end
                    end
                    default: begin
                        state_reg <= state_reg;
                    end
                endcase
            end
        end
    end

    // receive shifter, MSB first
    always_ff @(posedge linkClk) begin
        if (linkRst_reg) begin
            shift_reg <= '0;
        end else if (sclRise && bitCnt_reg < acs_pkg::BIT_ACK) begin
            shift_reg <= {shift_reg[6:0], sdaF};
        end
    end

    // master acknowledge sampled in the slot of each read byte
    always_ff @(posedge linkClk) begin
        if (linkRst_reg) begin
            mAck_reg <= 1'b0;
        end else if (sclRise && bitCnt_reg == acs_pkg::BIT_ACK) begin
            mAck_reg <= !sdaF;
        end
    end

    // register pointer; a start leaves it alone so a read follows the sub-address
    always_ff @(posedge linkClk) begin
        if (linkRst_reg) begin
            ptr_reg <= '0;
            autoInc_reg <= 1'b0;
        end else if (!busEv && sclFall && bitCnt_reg == acs_pkg::BIT_ACK) begin
            if (state_reg == acs_pkg::ST_SUB) begin
                ptr_reg <= shift_reg[6:0];
                autoInc_reg <= shift_reg[7];
            end else if (autoInc_reg && (state_reg == acs_pkg::ST_WR || (state_reg == acs_pkg::ST_RD && mAck_reg))) begin
                ptr_reg <= ptr_reg + 7'h01;
            end
        end
    end

    // requests to the store; one outstanding at a time, the stretch below keeps it so
    assign wrIssue = !busEv && state_reg == acs_pkg::ST_WR && sclFall && bitCnt_reg == acs_pkg::BIT_LAST;
    assign rdIssue = !busEv && state_reg == acs_pkg::ST_RD && bitCnt_reg == acs_pkg::BIT_FIRST
                     && !txValid_reg && !pending && !loadEv;
    always_ff @(posedge linkClk) begin
        if (linkRst_reg) begin
            reqTgl_reg <= 1'b0;
            reqWr_reg <= 1'b0;
            reqAddr_reg <= '0;
            reqWdata_reg <= '0;
        end else if (wrIssue) begin
            reqTgl_reg <= ~reqTgl_reg;
            reqWr_reg <= 1'b1;
            reqAddr_reg <= ptr_reg;
            reqWdata_reg <= shift_reg;
        end else if (rdIssue) begin
            reqTgl_reg <= ~reqTgl_reg;
            reqWr_reg <= 1'b0;
            reqAddr_reg <= ptr_reg;
        end
    end

    assign regBus.reqTgl = reqTgl_reg;
    assign regBus.reqWr = reqWr_reg;
    assign regBus.reqAddr = reqAddr_reg;
    assign regBus.reqWdata = reqWdata_reg;

    // transmit byte: loaded from the store, shifted on the falling SCL after each of bits 0 to 6
    always_ff @(posedge linkClk) begin
        if (linkRst_reg || state_reg != acs_pkg::ST_RD) begin
            txValid_reg <= 1'b0;
            txReg_reg <= '0;
            setupCnt_reg <= '0;
        end else if (loadEv && !reqWr_reg) begin
            txReg_reg <= regBus.rdData; // settled before the toggle crossed
            txValid_reg <= 1'b1;
            setupCnt_reg <= acs_pkg::SETUP_LOAD;
        end else begin
            if (setupCnt_reg != 3'h0) begin
                setupCnt_reg <= setupCnt_reg - 3'h1;
            end
            if (sclFall && bitCnt_reg < acs_pkg::BIT_LAST) begin
                txReg_reg <= {txReg_reg[6:0], 1'b0};
            end
            if (sclFall && bitCnt_reg == acs_pkg::BIT_ACK) begin
                txValid_reg <= 1'b0; // next byte fetched once the acknowledge slot ends
            end
        end
    end

    // open-drain drive: ack low through the slot, data bits, clock stretch
    // the stretch costs under a microsecond per read byte but removes any latency race
    always_ff @(posedge linkClk) begin
        if (linkRst_reg) begin
            sdaOe_reg <= 1'b0;
            sclOe_reg <= 1'b0;
        end else begin
            sdaOe_reg <= modeI2c && ((rxState && bitCnt_reg == acs_pkg::BIT_ACK && ackDrive_reg)
                         || (state_reg == acs_pkg::ST_RD && txValid_reg && bitCnt_reg < acs_pkg::BIT_ACK
                         && !txReg_reg[7])); // released in the master's slot
            sclOe_reg <= modeI2c && !sclF
                         && ((state_reg == acs_pkg::ST_RD && bitCnt_reg == acs_pkg::BIT_FIRST
                         && (!txValid_reg || setupCnt_reg != 3'h0))
                         || (state_reg == acs_pkg::ST_WR && bitCnt_reg == acs_pkg::BIT_ACK && pending));
        end
    end

    assign sdaOe = sdaOe_reg;
    assign sclOe = sclOe_reg;
    assign sdaOut = 1'b0;
    assign sclOut = 1'b0;

    default clocking cb @(posedge linkClk);
    endclocking
    default disable iff (linkRst_reg);

    property p_start_addr;
        (modeI2c && startDet && !stopDet) |=> (state_reg == acs_pkg::ST_ADDR && bitCnt_reg == acs_pkg::BIT_LEAD);
    endproperty
    a_start_addr: assert property (p_start_addr) else $error("start did not open address phase");

    property p_addr_miss;
        (!busEv && state_reg == acs_pkg::ST_ADDR && sclFall && bitCnt_reg == acs_pkg::BIT_LAST && !addrMatch)
        |=> !ackDrive_reg ##1 !sdaOe_reg;
    endproperty
    a_addr_miss: assert property (p_addr_miss) else $error("foreign address acknowledged");

    property p_addr_byte;
        (!busEv && state_reg == acs_pkg::ST_ADDR && sclFall && bitCnt_reg == acs_pkg::BIT_LAST && bootF
        && {shift_reg[7:1], 1'b0} == (strapF ? acs_pkg::ADDR_BYTE_WR_HI : acs_pkg::ADDR_BYTE_WR_LO))
        |=> ackDrive_reg ##1 sdaOe_reg;
    endproperty
    a_addr_byte: assert property (p_addr_byte) else $error("own address byte not acknowledged");

    property p_ack_hold;
        (modeI2c && state_reg inside {acs_pkg::ST_SUB, acs_pkg::ST_WR} && bitCnt_reg == acs_pkg::BIT_ACK && sclRise)
        |-> sdaOe_reg ##1 (sdaOe_reg || !sclF || busEv);
    endproperty
    a_ack_hold: assert property (p_ack_hold) else $error("acknowledge not held low");

    property p_autoinc;
        (!busEv && state_reg == acs_pkg::ST_WR && sclFall && bitCnt_reg == acs_pkg::BIT_ACK && autoInc_reg)
        |=> ptr_reg == 7'($past(ptr_reg) + 7'h01);
    endproperty
    a_autoinc: assert property (p_autoinc) else $error("pointer did not advance");

    property p_msb_first;
        (modeI2c && !busEv && state_reg == acs_pkg::ST_RD && txValid_reg && sclRise && bitCnt_reg < acs_pkg::BIT_ACK)
        |-> sdaF == txReg_reg[7];
    endproperty
    a_msb_first: assert property (p_msb_first) else $error("read bit on the wire differs");

    property p_nack_end;
        (!busEv && state_reg == acs_pkg::ST_RD && sclFall && bitCnt_reg == acs_pkg::BIT_ACK && !mAck_reg)
        |=> (state_reg == acs_pkg::ST_WAIT) ##1 !sdaOe_reg;
    endproperty
    a_nack_end: assert property (p_nack_end) else $error("sending went on after not-acknowledge");

    property p_stop;
        (modeI2c && stopDet) |=> (state_reg == acs_pkg::ST_IDLE) ##1 (!sdaOe_reg && !sclOe_reg);
    endproperty
    a_stop: assert property (p_stop) else $error("bus not released after stop");

    property p_stretch;
        (modeI2c && !busEv && state_reg == acs_pkg::ST_RD && bitCnt_reg == acs_pkg::BIT_FIRST
        && !txValid_reg && !sclF) |=> sclOe_reg;
    endproperty
    a_stretch: assert property (p_stretch) else $error("clock not held while data missing");

    property p_spi_mode;
        !modeI2c |=> (state_reg == acs_pkg::ST_IDLE && !sdaOe_reg && !sclOe_reg);
    endproperty
    a_spi_mode: assert property (p_spi_mode) else $error("lines driven with select low");

    property p_repeat_keep;
        (modeI2c && startDet && !stopDet && state_reg != acs_pkg::ST_IDLE) |=> $stable(ptr_reg);
    endproperty
    a_repeat_keep: assert property (p_repeat_keep) else $error("pointer lost on repeated start");

    property p_cov_write;
        state_reg == acs_pkg::ST_WR && sclFall && bitCnt_reg == acs_pkg::BIT_ACK && autoInc_reg;
    endproperty
    c_cov_write: cover property (p_cov_write);

    property p_cov_repeat;
        state_reg == acs_pkg::ST_WR && startDet && modeI2c;
    endproperty
    c_cov_repeat: cover property (p_cov_repeat);

    property p_cov_nack;
        state_reg == acs_pkg::ST_RD && sclFall && bitCnt_reg == acs_pkg::BIT_ACK && !mAck_reg;
    endproperty
    c_cov_nack: cover property (p_cov_nack);

    property p_cov_stretch;
        $rose(sclOe_reg);
    endproperty
    c_cov_stretch: cover property (p_cov_stretch);
endmodule

// >>> rtl/acs_pkg.sv
// constants and types for the accelerometer two-wire register slave
// Function
// - select pin high gives two-wire mode; low hands the pins to SPI
// - START is SDA falling while SCL high; bus busy afterwards
// - first byte holds 7-bit slave address and direction; respond only on match
// - address is six fixed bits plus the strap pin as LSB
// - address bytes 30h/31h with strap low, 32h/33h with strap high
// - transmitter releases SDA in acknowledge slot; receiver holds it low while SCL high
// - addressed receiver acknowledges address, sub-address and every written byte
// - sub-address: low seven bits pick register, top bit enables increment
// - with increment set, pointer advances after every data byte; here it does not advance after a not-acknowledged read byte
// - write: START, write address, sub-address, data bytes, STOP; direction fixed
// - master acknowledges read bytes, not-acknowledges the last, then STOP
// - bytes are eight bits, MSB first, any number per transaction
// - a receiver not ready may hold SCL low to stall
// - slave unable to take its address leaves SDA high in the slot
// - STOP is SDA rising while SCL high; slave releases the bus
// - works at standard and fast bus rates up to 400 kHz
// - factory trim copied into the registers at power-up before use
package acs_pkg;
    localparam int DATA_W = 8;
    localparam int REG_ADDR_W = 7;
    localparam int REG_COUNT = 128;
    localparam logic [6:0] LAST_REG = 7'h7F;
    localparam int TRIM_COUNT = 15;
    localparam logic [7:0] TRIM_SEED = 8'h5A;
    localparam logic [5:0] SLAVE_ADDR_HI = 6'h0C;
    localparam logic [7:0] ADDR_BYTE_WR_LO = 8'h30;
    localparam logic [7:0] ADDR_BYTE_WR_HI = 8'h32;
    localparam logic [3:0] BIT_FIRST = 4'h0;
    localparam logic [3:0] BIT_LAST = 4'h7;
    localparam logic [3:0] BIT_ACK = 4'h8;
    // count after a start: the clock fall that closes the start carries no bit, and one more wraps to zero
    localparam logic [3:0] BIT_LEAD = 4'hF;
    // positions in the synchroniser vector
    localparam int SYN_SDA = 0;
    localparam int SYN_SCL = 1;
    localparam int SYN_STRAP = 2;
    localparam int SYN_MODE = 3;
    localparam int SYN_ACK = 4;
    localparam int SYN_BOOT = 5;
    localparam logic [5:0] SYNC_IDLE = 6'h0B;
    // data setup before releasing a stretched clock
    localparam int LINK_PERIOD_NS = 64;
    localparam int SDA_SETUP_NS = 100;
    localparam int SDA_SETUP_CYC = (SDA_SETUP_NS + LINK_PERIOD_NS - 1) / LINK_PERIOD_NS;
    localparam logic [2:0] SETUP_LOAD = 3'(SDA_SETUP_CYC);
    typedef enum logic [2:0] {
        ST_IDLE = 3'h0,
        ST_ADDR = 3'h1,
        ST_SUB = 3'h2,
        ST_WR = 3'h3,
        ST_RD = 3'h4,
        ST_WAIT = 3'h5
    } acs_state_e;
endpackage

// >>> rtl/acs_reg_if.sv
// request and answer wires between the link engine and the register store
interface acs_reg_if;
    logic reqTgl;
    logic reqWr;
    logic [acs_pkg::REG_ADDR_W-1:0] reqAddr;
    logic [acs_pkg::DATA_W-1:0] reqWdata;
    logic ackTgl;
    logic [acs_pkg::DATA_W-1:0] rdData;
    logic bootDone;
    modport link (output reqTgl, reqWr, reqAddr, reqWdata, input ackTgl, rdData, bootDone);
    modport core (input reqTgl, reqWr, reqAddr, reqWdata, output ackTgl, rdData, bootDone);
endinterface

// >>> rtl/acs_reg_core.sv
// register store with power-up trim load, served by toggle handshake
module acs_reg_core #(
    parameter int TRIM_COUNT = acs_pkg::TRIM_COUNT
) (
    input wire logic clk,
    input wire logic rst,
    acs_reg_if.core regBus
);
    logic [acs_pkg::DATA_W-1:0] regFile [acs_pkg::REG_COUNT];
    logic [acs_pkg::REG_ADDR_W-1:0] bootIdx_reg;
    logic bootDone_reg;
    logic [2:0] reqSync_reg;
    logic reqSeen_reg;
    logic ackTgl_reg;
    logic [acs_pkg::DATA_W-1:0] rdData_reg;
    logic reqNew;

    // arbitrary factory pattern standing in for the non-volatile trim
    function automatic logic [7:0] trim_value(input logic [6:0] idx);
        trim_value = acs_pkg::TRIM_SEED ^ {1'b0, idx};
    endfunction

    // walk every entry once after reset so nothing reads undefined
    always_ff @(posedge clk) begin
        if (rst) begin
            bootIdx_reg <= '0;
            bootDone_reg <= 1'b0;
        end else if (!bootDone_reg) begin
            bootIdx_reg <= bootIdx_reg + 7'h01;
            if (bootIdx_reg == acs_pkg::LAST_REG) begin
                bootDone_reg <= 1'b1;
            end
        end
    end

    // storage: trim load first, link writes only afterwards
    always_ff @(posedge clk) begin
        if (!bootDone_reg) begin
            regFile[bootIdx_reg] <= (bootIdx_reg < 7'(TRIM_COUNT)) ? trim_value(bootIdx_reg) : '0;
        end else if (reqNew && regBus.reqWr) begin
            regFile[regBus.reqAddr] <= regBus.reqWdata;
        end
    end

    // request toggle crosses in three stages; counts once the last two agree
    always_ff @(posedge clk) begin
        if (rst) begin
            reqSync_reg <= '0;
        end else begin
            reqSync_reg <= {reqSync_reg[1:0], regBus.reqTgl};
        end
    end
    assign reqNew = bootDone_reg && (reqSync_reg[2] == reqSync_reg[1]) && (reqSync_reg[2] != reqSeen_reg);

    // answer: read data is registered on the same clk edge that flips the acknowledge toggle
    always_ff @(posedge clk) begin
        if (rst) begin
            reqSeen_reg <= 1'b0;
            ackTgl_reg <= 1'b0;
            rdData_reg <= '0;
        end else if (reqNew) begin
            reqSeen_reg <= reqSync_reg[2];
            ackTgl_reg <= ~ackTgl_reg;
            if (!regBus.reqWr) begin
                rdData_reg <= regFile[regBus.reqAddr];
            end
        end
    end

    assign regBus.ackTgl = ackTgl_reg;
    assign regBus.rdData = rdData_reg;
    assign regBus.bootDone = bootDone_reg;

    property p_trim_loaded;
        @(posedge clk) disable iff (rst)
        (!bootDone_reg && bootIdx_reg == 7'h03) |=> (regFile[3] == trim_value(7'h03));
    endproperty
    a_trim_loaded: assert property (p_trim_loaded) else $error("trim value not loaded");

    property p_quiet_in_boot;
        @(posedge clk) disable iff (rst)
        !bootDone_reg |=> $stable(ackTgl_reg);
    endproperty
    a_quiet_in_boot: assert property (p_quiet_in_boot) else $error("answer before trim load done");
endmodule

// >>> test/acs_i2c_master.sv
// bit-level two-wire bus master pulling the open-drain lines
module acs_i2c_master (
    input wire logic clk,
    input wire logic sdaW,
    input wire logic sclW,
    output logic sdaPull,
    output logic sclPull
);
    timeunit 1ns;
    timeprecision 1ps;
    int stalls = 0;
    initial begin
        sdaPull = 1'h0;
        sclPull = 1'h0;
    end
    task automatic tick(input int n);
        repeat (n) @(negedge clk);
    endtask
    // let scl go and wait, bounded, while the slave stretches it
    task automatic rise();
        sclPull = 1'h0;
        for (int k = 0; k < 4000 && !sclW; k++) tick(1);
        if (!sclW) begin
            stalls++;
            $display("unexpected at %0t: clock held low too long", $time);
        end
        tick(50);
    endtask
    // 1.5 us low, 1.0 us high gives 400 kHz; sda moves only while scl low
    task automatic bitx(input logic b, output logic r);
        tick(15);
        sdaPull = !b;
        tick(60);
        rise();
        r = sdaW;
        sclPull = 1'h1;
    endtask
    // start or repeated start: sda falls while scl high
    task automatic start();
        tick(15);
        sdaPull = 1'h0;
        tick(60);
        rise();
        sdaPull = 1'h1;
        tick(50);
        sclPull = 1'h1;
    endtask
    // stop: sda rises while scl high, then bus free time
    task automatic stop();
        tick(15);
        sdaPull = 1'h1;
        tick(60);
        rise();
        sdaPull = 1'h0;
        tick(70);
    endtask
    // msb first; in the ack slot sda is released unless acking a read byte
    task automatic xfer(input logic [7:0] w, input logic mack, output logic [7:0] r, output logic ack);
        logic a;
        for (int i = 7; i >= 0; i--) bitx(w[i], r[i]);
        bitx(!mack, a);
        ack = !a;
    endtask
endmodule

// >>> test/tb_acs_i2c_slave.sv
// self-checking bench for the two-wire register slave
module tb_acs_i2c_slave;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 1'h0;
    logic linkClk = 1'h0;
    logic rst = 1'h1;
    logic csSel = 1'h1;
    logic addressStrapBit = 1'h0;
    logic sclOe, sdaOe, sdaPull, sclPull, sclOut, sdaOut;
    // the device pulls a line low only while enabled and showing zero
    wire sda = !((sdaOe & !sdaOut) | sdaPull);
    wire scl = !((sclOe & !sclOut) | sclPull);
    int miscompares = 0;
    int n_tests = 0;
    always #10 clk = !clk;
    // link clock offset so its edges never line up with clk
    initial begin
        #7;
        forever #32 linkClk = !linkClk;
    end
    acs_i2c_slave dut (.clk(clk), .rst(rst), .linkClk(linkClk), .sclIn(scl), .sclOut(sclOut), .sclOe(sclOe),
        .sdaIn(sda), .sdaOut(sdaOut), .sdaOe(sdaOe), .csSel(csSel), .addressStrapBit(addressStrapBit));
    acs_i2c_master mst (.clk(clk), .sdaW(sda), .sclW(scl), .sdaPull(sdaPull), .sclPull(sclPull));
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        n_tests++;
        if (got !== exp) begin
            miscompares++;
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
        end
    endtask
    task automatic send(input logic [7:0] b, input logic e);
        logic [7:0] r;
        logic a;
        mst.xfer(b, 1'h0, r, a);
        chk({7'h00, a}, {7'h00, e});
    endtask
    task automatic recv(input logic mack, input logic [7:0] e);
        logic [7:0] r;
        logic a;
        mst.xfer(8'hFF, mack, r, a);
        chk(r, e);
    endtask
    task automatic t_write_read();
        mst.start();
        send(8'h30, 1'h1);
        send(8'h85, 1'h1);
        send(8'hA1, 1'h1);
        send(8'hB2, 1'h1);
        mst.stop();
        chk({7'h00, sdaOe | sclOe}, 8'h00);
        mst.start();
        send(8'h30, 1'h1);
        send(8'h85, 1'h1);
        mst.start();
        send(8'h31, 1'h1);
        recv(1'h1, 8'hA1);
        recv(1'h0, 8'hB2);
        mst.stop();
        $display("test write_read done");
    endtask
    // strap high moves the address; unincremented reads repeat one trim entry
    task automatic t_strap_trim();
        addressStrapBit = 1'h1;
        mst.start();
        send(8'h30, 1'h0);
        mst.stop();
        mst.start();
        send(8'h32, 1'h1);
        send(8'h03, 1'h1);
        mst.start();
        send(8'h33, 1'h1);
        recv(1'h1, acs_pkg::TRIM_SEED ^ 8'h03);
        recv(1'h0, acs_pkg::TRIM_SEED ^ 8'h03);
        mst.stop();
        $display("test strap_trim done");
    endtask
    task automatic t_select();
        csSel = 1'h0;
        mst.start();
        send(8'h32, 1'h0);
        mst.stop();
        csSel = 1'h1;
        mst.start();
        send(8'h32, 1'h1);
        mst.stop();
        $display("test select done");
    endtask
    task automatic tally_and_finish();
        miscompares += mst.stalls; // a stretch past the master's limit counts as a mismatch
        $display("comparisons %0d mismatches %0d", n_tests, miscompares);
        if (miscompares == 0 && n_tests > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    // reset long enough for the link side copy, then wait out the trim load
    initial begin
        repeat (8) @(negedge clk);
        rst = 1'h0;
        repeat (160) @(negedge clk);
        t_write_read();
        t_strap_trim();
        t_select();
        tally_and_finish();
    end
    // watchdog: the three tests need well under half this span
    initial begin
        repeat (90000) @(posedge clk);
        miscompares++;
        tally_and_finish();
    end
endmodule
